// ==== core/cssel_pkg.sv ====
// Shared constants and types for the command source selector
package cssel_pkg;

   // ****************************************
   // Register map (byte addresses, 32-bit words)
   // ****************************************
   localparam logic [7:0]  OFS_DISP_FMT   = 8'h00; // Unit and decimals
   localparam logic [7:0]  OFS_MAX_USER   = 8'h04; // Max user value
   localparam logic [7:0]  OFS_READOUT    = 8'h08; // Scaled user value
   localparam logic [7:0]  OFS_SITE_SEL   = 8'h0c; // Site control select
   localparam logic [7:0]  OFS_HAND_FREQ  = 8'h10; // HAND frequency source
   localparam logic [7:0]  OFS_HAND_RUN   = 8'h14; // HAND run source
   localparam logic [7:0]  OFS_AUTO_FREQ  = 8'h18; // AUTO frequency source
   localparam logic [7:0]  OFS_AUTO_RUN   = 8'h1c; // AUTO run source
   localparam logic [7:0]  OFS_MAX_FREQ   = 8'h20; // Max operating freq
   localparam logic [7:0]  OFS_PIN_ROLE   = 8'h24; // Input pin role
   localparam logic [7:0]  OFS_STATUS     = 8'h28; // Mode status

   // ****************************************
   // Reset values and field layout
   // ****************************************
   localparam logic [15:0] RST_WORD       = 16'h0000; // All settings
   localparam int unsigned DEC_LSB        = 0;  // Decimal places field
   localparam int unsigned DEC_MSB        = 3;
   localparam int unsigned UNIT_LSB       = 4;  // Unit code field
   localparam int unsigned UNIT_MSB       = 15;
   localparam logic [3:0]  DEC_MAX        = 4'h3; // Three decimal places

   // ****************************************
   // Setting codes
   // ****************************************
   localparam logic [15:0] ROLE_SEL_HAND  = 16'h0029; // Pin high = HAND
   localparam logic [15:0] ROLE_SEL_AUTO  = 16'h002a; // Pin high = AUTO
   localparam logic [15:0] ROLE_LOC_REM   = 16'h0038; // Pin high = remote
   localparam logic [15:0] SITE_STD       = 16'h0000; // Plain three-way
   localparam logic [15:0] SITE_STOP      = 16'h0001; // Stop on switch
   localparam logic [15:0] SITE_REMOTE    = 16'h0002; // Remote settings
   localparam logic [15:0] SITE_LOCAL     = 16'h0003; // Local settings
   localparam logic [15:0] SITE_FOLLOW    = 16'h0004; // Follow the side
   localparam logic [15:0] FSRC_KEYPAD    = 16'h0000;
   localparam logic [15:0] FSRC_RS485     = 16'h0001;
   localparam logic [15:0] FSRC_LAST      = 16'h0008;
   localparam logic [15:0] FSRC_UNUSED    = 16'h0005;
   localparam logic [15:0] RSRC_LAST      = 16'h0005;
   localparam logic [15:0] RSRC_UNUSED    = 16'h0004;
   localparam int unsigned FSRC_N         = 9;  // Frequency source codes
   localparam int unsigned RSRC_N         = 6;  // Run source codes

   // ****************************************
   // Scaling divider
   // ****************************************
   localparam logic [5:0]  DIV_LAST       = 6'd31; // 32 restoring steps

   typedef enum logic [1:0] {
      SCHEME_AUTO,
      SCHEME_HAND,
      SCHEME_OFF
   } cssel_hand_off_auto_scheme_t;

   typedef enum logic {
      DIV_IDLE,
      DIV_RUN
   } cssel_div_state_t;

endpackage

// ==== core/cssel_top.sv ====
// Command source selector with user display scaling and APB registers
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ns
module cssel_top
   import cssel_pkg::*;
(
   input  wire logic        clock,           // 25 MHz system clock
   input  wire logic        rstn,            // Async reset, active low
   input  wire logic [7:0]  paddr,           // APB byte address
   input  wire logic        psel,            // APB select
   input  wire logic        penable,         // APB access phase
   input  wire logic        pwrite,          // APB write
   input  wire logic [31:0] pwdata,          // APB write data
   output logic      [31:0] prdata,          // APB read data
   output logic             pready,          // APB ready
   output logic             pslverr,         // APB error, unmapped
   input  wire logic        key_auto,        // Keypad run-mode key pulse
   input  wire logic        key_hand,        // Keypad HAND key pulse
   input  wire logic        mi_pin,          // Input pin, asynchronous
   input  wire logic [15:0] operating_freq,  // Present frequency
   input  wire logic        run_req,         // Run command request
   input  wire logic        jog_req,         // Jog request
   output logic             run_permit,      // Run command accepted
   output logic             jog_permit,      // Jog accepted
   output logic      [15:0] freq_src_sel,    // Active frequency source
   output logic      [15:0] run_src_sel,     // Active run source
   output logic      [8:0]  freq_src_onehot, // Decoded frequency source
   output logic      [5:0]  run_src_onehot,  // Decoded run source
   output logic             hand_mode,       // HAND scheme active
   output logic             near_site_tag,   // Local tag shown
   output logic             far_site_tag,    // Remote tag shown
   output logic             site_stop,       // Stop pulse on switch
   output logic      [15:0] user_value,      // Scaled user value
   output logic             user_value_valid,// User value meaningful
   output logic             user_display_en, // User display enabled
   output logic      [3:0]  display_decimals,// Decimal places shown
   output logic      [11:0] display_unit     // Unit code shown
);
   import cssel_pkg::*;

   // ****************************************
   // Registers and state
   // ****************************************
   logic [15:0] fmt_q;          // Display format word
   logic [15:0] max_user_q;     // Max user value
   logic [15:0] site_q;         // Site control select
   logic [15:0] hand_freq_q;    // HAND frequency source
   logic [15:0] hand_run_q;     // HAND run source
   logic [15:0] auto_freq_q;    // AUTO frequency source
   logic [15:0] auto_run_q;     // AUTO run source
   logic [15:0] max_freq_q;     // Max operating frequency
   logic [15:0] role_q;         // Input pin role
   logic [31:0] prdata_q;       // Read data latched in setup
   logic        pslverr_q;      // Error latched in setup
   logic        mi_meta_q;      // Pin synchroniser, first stage
   logic        mi_sync_q;      // Pin synchroniser, second stage
   cssel_hand_off_auto_scheme_t scheme_q, scheme_d; // Three-way scheme
   logic        remote_q;       // Remote side selected
   logic        remote_d;
   logic        stop_q;         // Site stop pulse
   logic [15:0] fsel_q;         // Selected frequency source
   logic [15:0] rsel_q;         // Selected run source
   logic [15:0] user_q;         // Scaled user value
   cssel_div_state_t div_q;     // Divider state
   logic [5:0]  div_cnt_q;      // Divider step count
   logic [31:0] quo_q;          // Dividend, then quotient
   logic [16:0] rem_q;          // Partial remainder
   logic [15:0] divisor_q;      // Latched max frequency

   // ****************************************
   // APB decode
   // ****************************************
   wire setup_w  = psel && !penable;
   wire wr_w     = psel && penable && pwrite;
   wire hit_fmt  = (paddr == OFS_DISP_FMT);
   wire hit_mxu  = (paddr == OFS_MAX_USER);
   wire hit_rdo  = (paddr == OFS_READOUT);
   wire hit_site = (paddr == OFS_SITE_SEL);
   wire hit_hf   = (paddr == OFS_HAND_FREQ);
   wire hit_hr   = (paddr == OFS_HAND_RUN);
   wire hit_af   = (paddr == OFS_AUTO_FREQ);
   wire hit_ar   = (paddr == OFS_AUTO_RUN);
   wire hit_mxf  = (paddr == OFS_MAX_FREQ);
   wire hit_role = (paddr == OFS_PIN_ROLE);
   wire hit_stat = (paddr == OFS_STATUS);
   wire [15:0] wdat = pwdata[15:0];
   // Status: scheme, sides, stop pulse, valid flag
   wire [15:0] status_w = {10'h000, user_value_valid, stop_q, remote_q,
                           near_site_tag, scheme_q};
   logic [15:0] rd_mux;
   logic        rd_err;

   // Read selection, if/else chain on the address
   always_comb begin
      rd_err = 1'b0;
      if (hit_fmt) begin
         rd_mux = fmt_q;
      end else if (hit_mxu) begin
         rd_mux = max_user_q;
      end else if (hit_rdo) begin
         rd_mux = user_q;
      end else if (hit_site) begin
         rd_mux = site_q;
      end else if (hit_hf) begin
         rd_mux = hand_freq_q;
      end else if (hit_hr) begin
         rd_mux = hand_run_q;
      end else if (hit_af) begin
         rd_mux = auto_freq_q;
      end else if (hit_ar) begin
         rd_mux = auto_run_q;
      end else if (hit_mxf) begin
         rd_mux = max_freq_q;
      end else if (hit_role) begin
         rd_mux = role_q;
      end else if (hit_stat) begin
         rd_mux = status_w;
      end else begin
         rd_mux = RST_WORD; // Unmapped reads zero with an error
         rd_err = 1'b1;
      end
   end

   // Zero wait states: data is latched in the setup cycle
   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q && psel && penable;

   // Read data capture
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup_w) begin
         prdata_q  <= {16'h0000, rd_mux};
         pslverr_q <= rd_err;
      end
   end

   // Setting registers; readout and status ignore writes
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fmt_q       <= RST_WORD;
         max_user_q  <= RST_WORD;
         site_q      <= RST_WORD;
         hand_freq_q <= RST_WORD;
         hand_run_q  <= RST_WORD;
         auto_freq_q <= RST_WORD;
         auto_run_q  <= RST_WORD;
         max_freq_q  <= RST_WORD;
         role_q      <= RST_WORD;
      end else if (wr_w) begin
         if (hit_fmt) fmt_q <= wdat;
         if (hit_mxu) max_user_q <= wdat;
         if (hit_site) site_q <= wdat;
         if (hit_hf) hand_freq_q <= wdat;
         if (hit_hr) hand_run_q <= wdat;
         if (hit_af) auto_freq_q <= wdat;
         if (hit_ar) auto_run_q <= wdat;
         if (hit_mxf) max_freq_q <= wdat;
         if (hit_role) role_q <= wdat;
      end
   end

   // ****************************************
   // Display format
   // ****************************************
   // More than three decimals is clamped, the readout has no room
   wire [3:0] dec_w = fmt_q[DEC_MSB:DEC_LSB];
   assign display_decimals = (dec_w > DEC_MAX) ? DEC_MAX : dec_w;
   assign display_unit     = fmt_q[UNIT_MSB:UNIT_LSB];
   assign user_display_en  = (max_user_q != RST_WORD);

   // ****************************************
   // Pin synchroniser
   // ****************************************
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mi_meta_q <= 1'b0;
         mi_sync_q <= 1'b0;
      end else begin
         mi_meta_q <= mi_pin;
         mi_sync_q <= mi_meta_q;
      end
   end

   // ****************************************
   // Mode arbitration
   // ****************************************
   wire pin_hoa  = (role_q == ROLE_SEL_HAND) || (role_q == ROLE_SEL_AUTO);
   wire site_on  = (site_q != SITE_STD);
   wire lr_en    = site_on && !pin_hoa;
   wire pin_lr   = lr_en && (role_q == ROLE_LOC_REM);
   wire kbd_lr   = lr_en && !pin_lr;
   wire pin_off  = pin_hoa && !mi_sync_q;
   wire pin_hand = (role_q == ROLE_SEL_HAND) ? 1'b1 : 1'b0;

   // Three-way scheme; the pin outranks the keypad
   always_comb begin
      scheme_d = scheme_q;
      if (pin_hoa) begin
         if (!mi_sync_q) begin
            scheme_d = SCHEME_OFF;
         end else if (pin_hand) begin
            scheme_d = SCHEME_HAND;
         end else begin
            scheme_d = SCHEME_AUTO;
         end
      end else if (lr_en) begin
         scheme_d = SCHEME_AUTO; // Sides replace the scheme
      end else if (key_hand) begin
         scheme_d = SCHEME_HAND;
      end else if (key_auto || scheme_q == SCHEME_OFF) begin
         scheme_d = SCHEME_AUTO; // Leaving pin-forced OFF falls to AUTO
      end
   end

   // Side selection; the run-mode key picks remote, HAND key local
   always_comb begin
      remote_d = remote_q;
      if (!lr_en) begin
         remote_d = 1'b0;
      end else if (pin_lr) begin
         remote_d = mi_sync_q;
      end else if (key_hand) begin
         remote_d = 1'b0;
      end else if (key_auto) begin
         remote_d = 1'b1;
      end
   end

   // Which setting pair drives the sources
   logic use_hand;
   always_comb begin
      use_hand = 1'b0;
      if (!lr_en) begin
         use_hand = (scheme_d == SCHEME_HAND);
      end else if (site_q == SITE_REMOTE) begin
         use_hand = 1'b1;
      end else if (site_q == SITE_LOCAL) begin
         use_hand = 1'b0;
      end else begin
         use_hand = remote_d;
      end
   end

   wire switch_w = lr_en && (remote_d != remote_q);
   wire stop_d   = switch_w && (site_q == SITE_STOP);

   // Mode and sources move together on one edge
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         scheme_q <= SCHEME_AUTO;
         remote_q <= 1'b0;
         stop_q   <= 1'b0;
         fsel_q   <= RST_WORD;
         rsel_q   <= RST_WORD;
      end else begin
         scheme_q <= scheme_d;
         remote_q <= remote_d;
         stop_q   <= stop_d;
         fsel_q   <= use_hand ? hand_freq_q : auto_freq_q;
         rsel_q   <= use_hand ? hand_run_q : auto_run_q;
      end
   end

   assign hand_mode     = (scheme_q == SCHEME_HAND);
   assign near_site_tag = lr_en && !remote_q;
   assign far_site_tag  = lr_en && remote_q;
   assign site_stop     = stop_q;
   assign freq_src_sel  = fsel_q;
   assign run_src_sel   = rsel_q;
   assign run_permit    = run_req && !pin_off;
   assign jog_permit    = jog_req && !pin_off;

   // Source decode; unused and out-of-range codes select nothing
   genvar gi;
   generate
      for (gi = 0; gi < FSRC_N; gi++) begin : g_fdec
         assign freq_src_onehot[gi] = (fsel_q == 16'(gi)) &&
                                      (fsel_q != FSRC_UNUSED);
      end
      for (gi = 0; gi < RSRC_N; gi++) begin : g_rdec
         assign run_src_onehot[gi] = (rsel_q == 16'(gi)) &&
                                     (rsel_q != RSRC_UNUSED);
      end
   endgenerate

   // ****************************************
   // User value scaling
   // ****************************************
   // Sequential divider: one result every 33 cycles, far faster
   // than any display needs, and no wide combinational divide.
   wire [31:0] prod_w  = {16'h0000, operating_freq} * {16'h0000, max_user_q};
   wire [16:0] rsh_w   = {rem_q[15:0], quo_q[31]};
   wire        ge_w    = (rsh_w >= {1'b0, divisor_q});
   wire [16:0] rsub_w  = rsh_w - {1'b0, divisor_q};
   wire        done_w  = (div_q == DIV_RUN) && (div_cnt_q == DIV_LAST);
   wire [31:0] qnext_w = {quo_q[30:0], ge_w};
   wire        ovf_w   = (qnext_w[31:16] != 16'h0000);

   // Divider sequence and result
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         div_q     <= DIV_IDLE;
         div_cnt_q <= 6'h00;
         quo_q     <= 32'h0000_0000;
         rem_q     <= 17'h0_0000;
         divisor_q <= RST_WORD;
         user_q    <= RST_WORD;
      end else begin
         case (div_q)
            DIV_IDLE: begin
               quo_q     <= prod_w;
               rem_q     <= 17'h0_0000;
               divisor_q <= max_freq_q;
               div_cnt_q <= 6'h00;
               div_q     <= DIV_RUN;
            end
            DIV_RUN: begin
               quo_q     <= qnext_w;
               rem_q     <= ge_w ? rsub_w : rsh_w;
               div_cnt_q <= div_cnt_q + 6'h01;
               if (done_w) begin
                  div_q <= DIV_IDLE;
               end
            end
            default: div_q <= DIV_IDLE;
         endcase
         if (!user_display_en || divisor_q == RST_WORD) begin
            user_q <= RST_WORD;
         end else if (done_w) begin
            user_q <= ovf_w ? 16'hffff : qnext_w[15:0];
         end
      end
   end

   assign user_value       = user_q;
   assign user_value_valid = user_display_en &&
                             ((auto_freq_q == FSRC_KEYPAD) ||
                              (auto_freq_q == FSRC_RS485));

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   fmt_write_a: assert property (
      wr_w && hit_fmt && (pwdata[3:0] <= DEC_MAX) |=>
         display_decimals == $past(pwdata[3:0]) &&
         display_unit == $past(pwdata[15:4]))
      else $error("format word fields wrong");
   readout_zero_a: assert property (
      !user_display_en ##1 !user_display_en |-> user_value == 16'h0000)
      else $error("readout not zero while disabled");
   div_done_a: assert property (
      div_q == DIV_IDLE |-> ##[33:33] div_q == DIV_IDLE)
      else $error("divider period wrong");
   valid_src_a: assert property (
      user_value_valid |-> auto_freq_q <= FSRC_RS485 && max_user_q != 0)
      else $error("user value valid for wrong source");
   pin_off_a: assert property (
      pin_off |-> !run_permit && !jog_permit)
      else $error("run allowed with selector pin off");
   pin_forces_a: assert property (
      pin_hoa |-> !near_site_tag && !far_site_tag)
      else $error("site tag shown under pin scheme");
   tag_shown_a: assert property (
      lr_en |-> near_site_tag ^ far_site_tag)
      else $error("exactly one site tag expected");
   pin_side_a: assert property (
      pin_lr ##1 pin_lr |-> far_site_tag == $past(mi_sync_q))
      else $error("pin did not set the side");
   key_side_a: assert property (
      kbd_lr && key_auto && !key_hand ##1 lr_en |-> far_site_tag)
      else $error("run-mode key did not pick remote");
   std_src_a: assert property (
      !lr_en && scheme_d == SCHEME_AUTO |=>
         freq_src_sel == $past(auto_freq_q) &&
         run_src_sel == $past(auto_run_q))
      else $error("AUTO scheme uses wrong sources");
   unused_code_a: assert property (
      fsel_q == FSRC_UNUSED || fsel_q > FSRC_LAST |->
         freq_src_onehot == 9'h000)
      else $error("unused frequency code decoded");

   hand_cov_c:  cover property (scheme_q == SCHEME_AUTO ##1 hand_mode);
   far_cov_c:   cover property (near_site_tag ##1 far_site_tag);
   stop_cov_c:  cover property (site_stop);
   valid_cov_c: cover property (user_value_valid && user_value != 16'h0000);

endmodule

// ==== dv/cssel_panel.sv ====
// Keypad and input terminal model facing the selector
`timescale 1ns/1ns
module cssel_panel (
   input  wire logic clock,    // System clock
   output logic      key_auto, // Run-mode key pulse
   output logic      key_hand, // HAND key pulse
   output logic      mi_pin    // Terminal level
);
   // ****************************************
   // Keypad and terminal actions
   // ****************************************
   // Idle panel: no key held, terminal off
   initial begin
      key_auto = 1'b0;
      key_hand = 1'b0;
      mi_pin   = 1'b0;
   end

   // Keypad fitted so the HAND sources are reachable
   task automatic press(input logic hand);
      @(posedge clock);
      key_auto <= ~hand;
      key_hand <= hand;
      @(posedge clock);
      key_auto <= 1'b0;
      key_hand <= 1'b0;
      @(posedge clock);
   endtask

   // Terminal level moves only on a clock edge
   task automatic pin(input logic lvl);
      @(posedge clock);
      mi_pin <= lvl;
   endtask
endmodule

// ==== dv/cssel_top_tb.sv ====
// Self-checking bench for the command source selector
`timescale 1ns/1ns
module cssel_top_tb;
   import cssel_pkg::*;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic        clock, rstn;                   // Clock, reset
   logic        psel, penable;                 // APB phases
   logic        pwrite, pready, pslverr;
   logic [7:0]  paddr;                         // APB address
   logic [31:0] pwdata, prdata, rdat;          // APB data
   logic [15:0] opf, fsel, rsel, uval;         // Frequency, sources
   logic        run_req, jog_req, run_ok, jog_ok;
   logic        k_a, k_h, mi, hand, near, far, stop, uvv, uen, err;
   logic [8:0]  f1h;                           // Frequency decode
   logic [5:0]  r1h;                           // Run decode
   logic [3:0]  dec;                           // Decimal places
   logic [11:0] unit;                          // Unit code
   int          fails = 0, n_compared = 0, stops = 0, n0;

   always #20 clock = ~clock;
   // Stop is a one-cycle pulse, so count it rather than poll it
   always @(posedge clock) if (stop === 1'b1) stops++;

   cssel_panel p (.clock(clock), .key_auto(k_a), .key_hand(k_h),
                  .mi_pin(mi));
   cssel_top dut (.clock(clock), .rstn(rstn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .key_auto(k_a), .key_hand(k_h), .mi_pin(mi),
      .operating_freq(opf), .run_req(run_req), .jog_req(jog_req),
      .run_permit(run_ok), .jog_permit(jog_ok), .freq_src_sel(fsel),
      .run_src_sel(rsel), .freq_src_onehot(f1h), .run_src_onehot(r1h),
      .hand_mode(hand), .near_site_tag(near), .far_site_tag(far),
      .site_stop(stop), .user_value(uval), .user_value_valid(uvv),
      .user_display_en(uen), .display_decimals(dec),
      .display_unit(unit));

   // ****************************************
   // Bus cycles and comparisons
   // ****************************************
   // Setup then access; held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {16'h0000, d};
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) fails++;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   // Two extra edges: the source registers copy the settings one
   // edge after the write, and are read only once that has settled
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, d);
      repeat (2) @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 16'h0000);
      chk(rdat, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic summarize();
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      // Idle bus and inputs while reset is held
      clock   = 1'b0;
      rstn    = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
      opf     = 16'h0000;
      run_req = 1'b0;
      jog_req = 1'b0;
      tick(8);
      rstn <= 1'b1;
      rd(OFS_MAX_USER, 32'h0);
      rd(OFS_SITE_SEL, 32'h0);
      rd(OFS_HAND_FREQ, 32'h0);
      rd(OFS_HAND_RUN, 32'h0);
      chkb(hand, 1'b0);
      apb(1'b0, 8'h2c, 16'h0000);
      chkb(err, 1'b1);
      done("reset");
      wr(OFS_DISP_FMT, 16'h01a3);
      chk(32'(dec), 32'h3);
      chk(32'(unit), 32'h01a);
      wr(OFS_MAX_FREQ, 16'h1770);
      wr(OFS_MAX_USER, 16'h03e8);
      opf <= 16'h0bb8;
      tick(70);
      rd(OFS_READOUT, 32'h01f4);
      opf <= 16'h1770;
      tick(70);
      chk(32'(uval), 32'h03e8);
      chkb(uen, 1'b1);
      wr(OFS_AUTO_FREQ, FSRC_RS485);
      chkb(uvv, 1'b1);
      wr(OFS_AUTO_FREQ, 16'h0002);
      chkb(uvv, 1'b0);
      wr(OFS_MAX_USER, 16'h0000);
      tick(70);
      rd(OFS_READOUT, 32'h0);
      chkb(uen, 1'b0);
      done("scaling");
      p.press(1'b1);
      chkb(hand, 1'b1);
      for (int c = 0; c < 9; c++) begin
         wr(OFS_HAND_FREQ, 16'(c));
         chk(32'(f1h), (c == 5) ? 32'h0 : 32'h1 << c);
      end
      for (int c = 0; c < 6; c++) begin
         wr(OFS_HAND_RUN, 16'(c));
         chk(32'(r1h), (c == 4) ? 32'h0 : 32'h1 << c);
      end
      chk(32'(rsel), 32'h5);
      chk(32'(fsel), 32'h8);
      p.press(1'b0);
      chk(32'(fsel), 32'h2);
      done("hand_auto");
      run_req <= 1'b1;
      jog_req <= 1'b1;
      wr(OFS_PIN_ROLE, ROLE_SEL_HAND);
      tick(4);
      chkb(run_ok, 1'b0);
      chkb(jog_ok, 1'b0);
      p.pin(1'b1);
      tick(4);
      chkb(hand, 1'b1);
      chkb(run_ok, 1'b1);
      p.press(1'b0);
      chkb(hand, 1'b1);
      wr(OFS_SITE_SEL, SITE_FOLLOW);
      chkb(far | near, 1'b0);
      done("pin_select");
      wr(OFS_PIN_ROLE, 16'h0000);
      p.pin(1'b0);
      p.press(1'b0);
      chkb(far, 1'b1);
      chk(32'(fsel), 32'h8);
      p.press(1'b1);
      chkb(near, 1'b1);
      chk(32'(fsel), 32'h2);
      wr(OFS_PIN_ROLE, ROLE_LOC_REM);
      p.pin(1'b1);
      tick(4);
      chkb(far, 1'b1);
      p.press(1'b1);
      chkb(far, 1'b1);
      wr(OFS_SITE_SEL, SITE_STD);
      chkb(far, 1'b0);
      done("site");
      wr(OFS_PIN_ROLE, 16'h0000);
      wr(OFS_SITE_SEL, SITE_STOP);
      p.press(1'b1);
      n0 = stops;
      p.press(1'b0);
      tick(1);
      chk(32'(stops - n0), 32'h1);
      wr(OFS_SITE_SEL, SITE_REMOTE);
      p.press(1'b1);
      chk(32'(fsel), 32'h8);
      wr(OFS_SITE_SEL, SITE_LOCAL);
      p.press(1'b0);
      chk(32'(fsel), 32'h2);
      done("site_codes");
      summarize();
   end

   // Whole run is near 440 cycles; cut a hang well beyond that
   initial begin
      tick(20000);
      fails++;
      summarize();
   end
endmodule
